// >>> hdl/uart_buffer_map.vh
// register offsets, frame bit counts, reset values and prescale codes
`ifndef UART_BUFFER_MAP_VH
`define UART_BUFFER_MAP_VH

`define SERIAL_DATA_BUFFER_ADDR   8'h99
`define SERIAL_DATA_BUFFER_RESET  8'h00
`define PRESCALE_DIV4             2'h1
`define PRESCALE_DIV12            2'h0
`define PRESCALE_DIV48            2'h2
`define PRESCALE_COUNT4           6'h03
`define PRESCALE_COUNT12          6'h0B
`define PRESCALE_COUNT48          6'h2F
`define FRAME_BITS8               4'hA
`define FRAME_BITS9               4'hB

`endif

// >>> hdl/baud_tick_gen.v
// baud timer: prescaler, 8-bit reload timer, half-rate toggle
`timescale 1ns/1ps
`default_nettype none

module baud_tick_gen (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       timerDirectClockSelect,
   input  wire [1:0] timerPrescaleSelect,
   input  wire [7:0] reloadValue,
   output reg        baudTick
);

`include "uart_buffer_map.vh"

   reg  [5:0] preCnt_r;
   reg  [7:0] timer_r;
   reg        half_r;
   reg  [5:0] preLimit;
   wire       timerClk;

   // ************************************************************
   // prescaler
   // ************************************************************
   // decode of the prescale field; don't-care in direct mode
   always @* begin
      case (timerPrescaleSelect)
         `PRESCALE_DIV4:  preLimit = `PRESCALE_COUNT4;   // see RQ5
         `PRESCALE_DIV12: preLimit = `PRESCALE_COUNT12;  // see RQ5
         `PRESCALE_DIV48: preLimit = `PRESCALE_COUNT48;  // see RQ5
         default:         preLimit = `PRESCALE_COUNT12;
      endcase
   end

   // direct select bypasses the divider entirely
   assign timerClk = timerDirectClockSelect |
                     (preCnt_r >= preLimit);           // see RQ6

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         preCnt_r <= 6'h00;
      end else if (timerDirectClockSelect || preCnt_r >= preLimit) begin
         preCnt_r <= 6'h00;
      end else begin
         preCnt_r <= preCnt_r + 6'h01;
      end
   end

   // ************************************************************
   // reload timer
   // ************************************************************
   // overflow at 256 reloads; every second overflow is one bit time
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_r  <= 8'h00;
         half_r   <= 1'b0;
         baudTick <= 1'b0;
      end else begin
         baudTick <= 1'b0;
         if (timerClk) begin
            if (timer_r == 8'hFF) begin
               timer_r  <= reloadValue;
               half_r   <= ~half_r;
               baudTick <= half_r;                     // see RQ7
            end else begin
               timer_r <= timer_r + 8'h01;
            end
         end
      end
   end

endmodule // baud_tick_gen

`default_nettype wire

// >>> hdl/uart_data_buffer.v
// serial port data buffer with transmit shifter, receiver and baud select
// Contract
// RQ1: the buffer address writes the transmit shifter and reads the receive latch, never the sent byte.
// RQ2: a written byte is held whole in the shifter until it is sent.
// RQ3: the write alone starts the frame.
// RQ4: a read returns the last received character.
// RQ5: prescale field 01 gives divide by 4, 00 by 12, 10 by 48.
// RQ6: with direct select set the timer counts the core clock and ignores the field.
// RQ7: baud is timer clock over twice the count from reload to 256.
// RQ8: in multiprocessor mode a receive event is raised only when the ninth bit is 1; the code filters only in nine-bit mode.
`timescale 1ns/1ps
`default_nettype none

module uart_data_buffer (
   // clock, reset and register bus
   input  wire       clk,
   input  wire       reset_n,
   input  wire [7:0] regAddr,
   input  wire       regWrite,
   input  wire       regRead,
   input  wire [7:0] regWdata,
   output reg  [7:0] regRdata,
   // baud timer selection
   input  wire       timerDirectClockSelect,
   input  wire [1:0] timerPrescaleSelect,
   input  wire [7:0] reloadValue,
   // frame format and receive control
   input  wire       nineBitMode,
   input  wire       txNinthBit,
   input  wire       receiveEnable,
   input  wire       multiprocReceiveEnable,
   // busy level, done pulses and ninth received bit
   output wire       txBusy,
   output reg        txDone,
   output reg        rxDone,
   output reg        rxNinthBit,
   // serial pins; the receive pin is asynchronous
   output reg        txLine,
   input  wire       rxLine
);

`include "uart_buffer_map.vh"

   // ************************************************************
   // declarations
   // ************************************************************
   // one-hot receive states
   localparam ST_IDLE  = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_STOP  = 3'b100;

   // timer tick and address decode
   wire        baudTick;
   wire        bufHit;
   wire        bufRead;
   wire        txStart;
   wire        txNinth;
   wire        rxKeep;

   // transmitter state and its next values
   reg  [9:0]  txShift_r;
   reg  [3:0]  txCnt_r;
   reg         txActive_r;
   reg  [9:0]  txShift_nxt;
   reg  [3:0]  txCnt_nxt;
   reg         txActive_nxt;
   reg         txLine_nxt;
   reg         txDone_nxt;

   // receiver state and line synchroniser
   reg  [7:0]  rxLatch_r;
   reg  [8:0]  rxShift_r;
   reg  [3:0]  rxBitCnt_r;
   reg  [2:0]  rxState_r;
   reg         rxSync1_r;
   reg         rxSync2_r;

   // ************************************************************
   // baud timer
   // ************************************************************
   // shared by both directions, so rx and tx bit edges line up
   baud_tick_gen i_baud_tick_gen (
      .clk                    (clk),
      .reset_n                (reset_n),
      .timerDirectClockSelect (timerDirectClockSelect),
      .timerPrescaleSelect    (timerPrescaleSelect),
      .reloadValue            (reloadValue),
      .baudTick               (baudTick)
   );

   // ************************************************************
   // address decode
   // ************************************************************
   // one address, two registers: writes load, reads see the latch
   assign bufHit  = (regAddr == `SERIAL_DATA_BUFFER_ADDR);
   assign bufRead = regRead && bufHit;                 // see RQ1
   // a write while busy is dropped so the shifter stays whole
   assign txStart = !txActive_r && regWrite && bufHit; // see RQ3
   // without the ninth bit this slot carries the stop bit
   assign txNinth = nineBitMode ? txNinthBit : 1'b1;
   // address filter: data bytes dropped in multiprocessor mode with nine-bit frames
   assign rxKeep  = !(nineBitMode && multiprocReceiveEnable &&
                      !rxShift_r[8]);                  // see RQ8
   assign txBusy  = txActive_r;

   // ************************************************************
   // register read
   // ************************************************************
   // only the receive latch is visible; unmapped reads return zero
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= `SERIAL_DATA_BUFFER_RESET;
      end else if (bufRead) begin
         regRdata <= rxLatch_r;                        // see RQ1 see RQ4
      end else begin
         regRdata <= 8'h00;
      end
   end

   // ************************************************************
   // transmitter
   // ************************************************************
   // next values: start, eight data bits lsb first, optional ninth,
   // stop; the shifter refills with ones so the line ends high
   always @* begin
      txShift_nxt  = txShift_r;
      txCnt_nxt    = txCnt_r;
      txActive_nxt = txActive_r;
      txLine_nxt   = txLine;
      txDone_nxt   = 1'b0;
      if (txStart) begin
         txActive_nxt = 1'b1;                          // see RQ3
         txShift_nxt  = {txNinth, regWdata, 1'b0};     // see RQ2
         txCnt_nxt    = nineBitMode ? `FRAME_BITS9 : `FRAME_BITS8;
      end else if (txActive_r && baudTick) begin
         txLine_nxt  = txShift_r[0];                   // see RQ2
         txShift_nxt = {1'b1, txShift_r[9:1]};
         txCnt_nxt   = txCnt_r - 4'h1;
         if (txCnt_r == 4'h0) begin
            txActive_nxt = 1'b0;
            txDone_nxt   = 1'b1;
            txLine_nxt   = 1'b1;
         end
      end
   end

   // transmit registers; line idles high out of reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txShift_r  <= 10'h3FF;
         txCnt_r    <= 4'h0;
         txActive_r <= 1'b0;
         txLine     <= 1'b1;
         txDone     <= 1'b0;
      end else begin
         txShift_r  <= txShift_nxt;
         txCnt_r    <= txCnt_nxt;
         txActive_r <= txActive_nxt;
         txLine     <= txLine_nxt;
         txDone     <= txDone_nxt;
      end
   end

   // ************************************************************
   // receiver
   // ************************************************************
   // line passes two flops before anything looks at it
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rxSync1_r <= 1'b1;
         rxSync2_r <= 1'b1;
      end else begin
         rxSync1_r <= rxLine;
         rxSync2_r <= rxSync1_r;
      end
   end

   // samples once per bit tick; coarse, no mid-bit alignment
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rxState_r  <= ST_IDLE;
         rxShift_r  <= 9'h000;
         rxBitCnt_r <= 4'h0;
         rxLatch_r  <= `SERIAL_DATA_BUFFER_RESET;
         rxNinthBit <= 1'b0;
         rxDone     <= 1'b0;
      end else begin
         rxDone <= 1'b0;
         case (rxState_r)
            ST_IDLE: begin
               if (receiveEnable && !rxSync2_r && baudTick) begin
                  rxState_r  <= ST_SHIFT;
                  rxBitCnt_r <= nineBitMode ? 4'h9 : 4'h8;
               end
            end
            ST_SHIFT: begin
               if (baudTick) begin
                  if (nineBitMode) begin
                     rxShift_r <= {rxSync2_r, rxShift_r[8:1]};
                  end else begin
                     rxShift_r <= {1'b0, rxSync2_r, rxShift_r[7:1]};
                  end
                  rxBitCnt_r <= rxBitCnt_r - 4'h1;
                  if (rxBitCnt_r == 4'h1) begin
                     rxState_r <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (baudTick) begin
                  rxState_r <= ST_IDLE;
                  // address filter: drop data bytes when enabled
                  if (rxKeep) begin                       // see RQ8
                     rxLatch_r  <= rxShift_r[7:0];        // see RQ4
                     rxNinthBit <= nineBitMode ? rxShift_r[8] : rxSync2_r;
                     rxDone     <= 1'b1;                  // see RQ8
                  end
               end
            end
            default: rxState_r <= ST_IDLE;
         endcase
      end
   end

endmodule // uart_data_buffer

`default_nettype wire

// >>> tb/uart_data_buffer_props.sv
// port assertions for the serial data buffer
`timescale 1ns/1ps
`default_nettype none
`include "uart_buffer_map.vh"
module uart_data_buffer_props (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [7:0] regAddr,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdata,
   input wire logic       nineBitMode,
   input wire logic       multiprocReceiveEnable,
   input wire logic       txBusy,
   input wire logic       txDone,
   input wire logic       rxDone,
   input wire logic       rxNinthBit,
   input wire logic       txLine
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // buffer write taken while the shifter is idle
   sequence wrIdle;
      regWrite && regAddr == `SERIAL_DATA_BUFFER_ADDR && !txBusy;
   endsequence
   write_starts_a: assert property (wrIdle |=> txBusy)
      else $error("write did not start a frame");
   busy_holds_a: assert property (txBusy |=> txBusy || txDone)
      else $error("frame dropped before its end");
   busy_ends_a: assert property ($fell(txBusy) |-> txDone)
      else $error("busy fell without done");
   idle_high_a: assert property (!txBusy |-> txLine)
      else $error("line not idle high");
   rx_pulse_a: assert property (rxDone |=> !rxDone)
      else $error("receive pulse too long");
   addr_filter_a: assert property (rxDone && nineBitMode &&
      multiprocReceiveEnable |-> rxNinthBit)
      else $error("data frame passed the filter");
   other_addr_a: assert property (regRead &&
      regAddr != `SERIAL_DATA_BUFFER_ADDR |=> regRdata == 8'h00)
      else $error("other address read not zero");
   no_read_a: assert property (!$past(regRead) |->
      regRdata == 8'h00)
      else $error("read data without a read");
endmodule // uart_data_buffer_props
bind uart_data_buffer uart_data_buffer_props i_uart_data_buffer_props (
   .clk, .reset_n, .regAddr, .regWrite, .regRead, .regRdata, .nineBitMode,
   .multiprocReceiveEnable, .txBusy, .txDone, .rxDone, .rxNinthBit, .txLine);
`default_nettype wire

// >>> tb/serial_peer.sv
// far-end serial device model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   input  wire logic clk,
   output var  logic line
);
   // line rests high between frames, as a pulled-up idle line would
   initial line = 1'b1;
   // start bit, n data bits lsb first, stop bit; bt cycles each
   task automatic send(input logic [8:0] d, input int n, input int bt);
      for (int i = -1; i <= n; i++) begin
         line <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
         repeat (bt) @(posedge clk);
      end
   endtask
endmodule // serial_peer
`default_nettype wire

// >>> tb/test_uart_data_buffer.sv
// self-checking bench for the serial data buffer
`timescale 1ns/1ps
`default_nettype none
`include "uart_buffer_map.vh"
module test_uart_data_buffer;
   logic clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, reloadValue = 8'hFF;
   logic timerDirectClockSelect = 1'b1, nineBitMode = 1'b0;
   logic txNinthBit = 1'b0, multiprocReceiveEnable = 1'b0, rdSeen = 1'b0;
   logic [1:0] timerPrescaleSelect = 2'h0;
   logic [7:0] regRdata, lastRx = 8'h00;
   logic txBusy, txDone, rxDone, rxNinthBit, txLine, rxLine;
   logic [8:0] expQ[$];
   logic [31:0] seed = 32'hC1DC3175;
   logic [2:0] modeSel[6] = '{3'h7, 3'h1, 3'h0, 3'h2, 3'h4, 3'h4};
   logic [7:0] relTab[6] = '{8'hF0, 8'hFC, 8'hFE, 8'hFF, 8'hF8, 8'hF8};
   int err_count = 0, n_checks = 0, rxCount = 0, bt;
   uart_data_buffer i_uart_data_buffer (.clk, .reset_n, .regAddr, .regWrite,
      .regRead, .regWdata, .regRdata, .timerDirectClockSelect,
      .timerPrescaleSelect, .reloadValue, .nineBitMode, .txNinthBit,
      .receiveEnable(1'b1), .multiprocReceiveEnable, .txBusy, .txDone,
      .rxDone, .rxNinthBit, .txLine, .rxLine);
   serial_peer i_serial_peer (.clk, .line(rxLine));
   // 40 ns core clock
   initial forever #20 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // bit time in core clocks for a {direct, field} select and reload
   function automatic int bitTime(input logic [2:0] s, input logic [7:0] r);
      int dv;
      dv = s[2] ? 1 : s[1:0] == 2'h1 ? 4 : s[1:0] == 2'h2 ? 48 : 12;
      return 2 * (256 - r) * dv;
   endfunction
   task automatic chk(input string nm, input logic [8:0] s, e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one-cycle strobe; a read notes its expected data
   task automatic acc(input logic wr, input logic [7:0] a, d);
      if (!wr)
         expQ.push_back({1'b0, d});
      regAddr <= a;
      regWdata <= d;
      regWrite <= wr;
      regRead <= !wr;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      // idle edge so back-to-back calls never reassign a strobe
      @(posedge clk);
   endtask
   // watcher: read data stands one cycle after the strobe edge
   always @(posedge clk) begin
      if (rdSeen)
         chk("read data", {1'b0, regRdata}, expQ.pop_front());
      rdSeen <= regRead;
      if (rxDone)
         rxCount++;
   end
   // full-duplex frame; peer starts half a bit late so rx samples mid-bit
   task automatic frame(input logic [8:0] tx, rx, input int n, logic got);
      int k;
      int c0;
      c0 = rxCount;
      txNinthBit <= tx[8];
      acc(1'b1, `SERIAL_DATA_BUFFER_ADDR, tx[7:0]);
      // timer counts up from zero after reset: allow a full 256 count
      for (k = 0; txLine && k < 4 * bt + 600; k++)
         @(posedge clk);
      if (txLine) begin
         err_count++;
         wrap_up();
      end
      fork
         begin
            repeat (bt / 2) @(posedge clk);
            i_serial_peer.send(rx, n, bt);
         end
         for (k = -1; k <= n; k++) begin
            repeat (k < 0 ? bt / 2 : bt) @(posedge clk);
            chk("tx bit", txLine, k < 0 ? 0 : k == n ? 1 : tx[k]);
         end
      join
      repeat (bt) @(posedge clk);
      chk("rx count", 9'(rxCount - c0), 9'(got));
      if (got && n == 9)
         chk("ninth bit", rxNinthBit, rx[8]);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      acc(1'b0, `SERIAL_DATA_BUFFER_ADDR, `SERIAL_DATA_BUFFER_RESET);
      acc(1'b0, 8'h98, 8'h00);
      $display("reset read test done");
      for (int m = 0; m < 6; m++) begin
         seed = lfsr(seed);
         timerDirectClockSelect <= modeSel[m][2];
         timerPrescaleSelect <= modeSel[m][1:0];
         reloadValue <= relTab[m];
         nineBitMode <= m > 3;
         multiprocReceiveEnable <= m > 3;
         bt = bitTime(modeSel[m], relTab[m]);
         @(posedge clk);
         frame(seed[8:0], {m == 5, seed[23:16]}, m > 3 ? 9 : 8, m != 4);
         if (m != 4)
            lastRx = seed[23:16];
         acc(1'b0, `SERIAL_DATA_BUFFER_ADDR, lastRx);
         repeat (2) @(posedge clk);
         $display("frame test %0d done", m);
      end
      wrap_up();
   end
endmodule // test_uart_data_buffer
`default_nettype wire
